/* File: hdl/flash_query_map.svh */
// How it works
// - Query bytes appear on low data lanes
// - Upper data lanes read zero during query
// - Offsets are word addresses, table at 10h
// - 10h-12h return signature 51, 52, 59
// - 13h-14h return command set code
// - 15h-16h return table pointer 0A, 01
// - 17h-18h return zero, no alternate set
// - 19h-1Ah return zero, no secondary table
// - 1Bh-1Ch return core supply 17, 20
// - 1Dh-1Eh return program supply 85, 95
// - 1Fh returns 06, 21h returns 0A
// - 20h returns 0B large, 0A smaller
// - 23h-25h return max factors 02/01
// - 22h and 26h return zero
// - Offsets 01h-0Fh reserved, read zero
// - Write active while select and strobe low
// - Host ends write by raising both strobes together
// - Strobe still low after write starts read
// - Host toggles select after write
// - Host holds write protect during operation
// - Suspended-erase writes use same protocol
`ifndef FLASH_QUERY_MAP_SVH
`define FLASH_QUERY_MAP_SVH

// ----------------------------------------
// Table offsets and contents
// ----------------------------------------
`define OFS_SIGNATURE       9'h010
`define OFS_CMDSET_LO       9'h013
`define OFS_CMDSET_HI       9'h014
`define OFS_EXT_PTR_LO      9'h015
`define OFS_EXT_PTR_HI      9'h016
`define OFS_ALT_LO          9'h017
`define OFS_ALT_HI          9'h018
`define OFS_SEC_LO          9'h019
`define OFS_SEC_HI          9'h01A
`define OFS_CORE_MIN        9'h01B
`define OFS_CORE_MAX        9'h01C
`define OFS_PROG_MIN        9'h01D
`define OFS_PROG_MAX        9'h01E
`define OFS_WORD_TYP        9'h01F
`define OFS_BUF_TYP         9'h020
`define OFS_ERASE_TYP       9'h021
`define OFS_CHIP_TYP        9'h022
`define OFS_WORD_MAX        9'h023
`define OFS_BUF_MAX         9'h024
`define OFS_ERASE_MAX       9'h025
`define OFS_CHIP_MAX        9'h026
`define SIG_BYTE0           8'h51
`define SIG_BYTE1           8'h52
`define SIG_BYTE2           8'h59
`define EXT_PTR_LO_VAL      8'h0A
`define EXT_PTR_HI_VAL      8'h01
`define CORE_MIN_VAL        8'h17
`define CORE_MAX_VAL        8'h20
`define PROG_MIN_VAL        8'h85
`define PROG_MAX_VAL        8'h95
`define WORD_TYP_VAL        8'h06
`define BUF_TYP_LARGE       8'h0B
`define BUF_TYP_SMALL       8'h0A
`define ERASE_TYP_VAL       8'h0A
`define MAX_FACTOR_VAL      8'h02
`define BUF_MAX_LARGE       8'h01
`define ZERO_BYTE           8'h00

// ----------------------------------------
// Flash commands
// ----------------------------------------
`define CMD_QUERY           8'h98
`define CMD_READ_ARRAY      8'hFF
`define CMD_READ_STATUS     8'h70
`define CMD_READ_ID         8'h90
`define ERASED_WORD         16'hFFFF
`define STATUS_READY        16'h0080

// ----------------------------------------
// Host APB map and fields
// ----------------------------------------
`define APB_CTRL            12'h000
`define APB_ADDR            12'h004
`define APB_WDATA           12'h008
`define APB_RDATA           12'h00C
`define APB_STATUS          12'h010
`define CTRL_START          0
`define CTRL_WRITE          1
`define CTRL_END_BY_CE      2
`define CTRL_WP_LEVEL       3
`define STAT_BUSY           0
`define STAT_DONE           1
`define CTRL_RESET          4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS       50
`define WRITE_LOW_NS        40
`define WRITE_HIGH_NS       20
`define READ_ACCESS_NS      96
`define CEIL_CYC(ns)        (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_LOW_CYC       `CEIL_CYC(`WRITE_LOW_NS)
`define WRITE_HIGH_CYC      `CEIL_CYC(`WRITE_HIGH_NS)
`define READ_ACCESS_CYC     `CEIL_CYC(`READ_ACCESS_NS)

`endif

/* File: hdl/flash_query_pkg.sv */
package flash_query_pkg;
   typedef enum logic [1:0] {
      MODE_ARRAY = 2'b01,
      MODE_QUERY = 2'b10
   } read_mode_type;

   typedef enum logic [5:0] {
      ST_IDLE     = 6'b000001,
      ST_WR_SETUP = 6'b000010,
      ST_WR_PULSE = 6'b000100,
      ST_WR_END   = 6'b001000,
      ST_RD_LATCH = 6'b010000,
      ST_RD_WAIT  = 6'b100000
   } host_state_type;
endpackage

/* File: hdl/flash_bus_if.sv */
`timescale 1ns/1ps
interface flash_bus_if;
   logic        chip_select_n;
   logic        write_strobe_n;
   logic        output_enable_n;
   logic        address_valid_strobe_low;
   logic        write_protect_n;
   logic [8:0]  addr;
   logic [15:0] dq_host_out;
   logic        dq_host_oe;
   logic [15:0] dq_dev_out;
   logic        dq_dev_oe;
   logic [15:0] dq;

   // Weak pull-up when nobody drives
   assign dq = dq_dev_oe ? dq_dev_out : (dq_host_oe ? dq_host_out : 16'hFFFF);

   modport device (
      input  chip_select_n, write_strobe_n, output_enable_n,
      input  address_valid_strobe_low, write_protect_n, addr, dq,
      output dq_dev_out, dq_dev_oe
   );
   modport host (
      output chip_select_n, write_strobe_n, output_enable_n,
      output address_valid_strobe_low, write_protect_n, addr,
      output dq_host_out, dq_host_oe,
      input  dq
   );
endinterface

/* File: hdl/flash_query_table.sv */
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "flash_query_map.svh"
module flash_query_table
   import flash_query_pkg::*;
#(
   // Arbitrary value, stands in for a real command set code
   parameter logic [15:0] CMDSET_CODE   = 16'h5A3C,
   // Selects the largest density figures
   parameter bit          LARGE_DENSITY = 1'b0
) (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Flash bus
   flash_bus_if.device     bus,
   // User side
   input  wire logic       erase_suspended,
   output logic            query_mode,
   output logic            command_valid,
   output logic [7:0]      command_code
);

   // ----------------------------------------
   // Table lookup
   // ----------------------------------------
   function automatic logic [7:0] table_byte(input logic [8:0] ofs);
      logic [7:0] b;
      b = `ZERO_BYTE;
      case (ofs)
         `OFS_SIGNATURE: begin
            b = `SIG_BYTE0;
         end
         `OFS_SIGNATURE + 9'h001: begin
            b = `SIG_BYTE1;
         end
         `OFS_SIGNATURE + 9'h002: begin
            b = `SIG_BYTE2;
         end
         `OFS_CMDSET_LO: begin
            b = CMDSET_CODE[7:0];
         end
         `OFS_CMDSET_HI: begin
            b = CMDSET_CODE[15:8];
         end
         `OFS_EXT_PTR_LO: begin
            b = `EXT_PTR_LO_VAL;
         end
         `OFS_EXT_PTR_HI: begin
            b = `EXT_PTR_HI_VAL;
         end
         `OFS_ALT_LO, `OFS_ALT_HI: begin
            b = `ZERO_BYTE;
         end
         `OFS_SEC_LO, `OFS_SEC_HI: begin
            b = `ZERO_BYTE;
         end
         `OFS_CORE_MIN: begin
            b = `CORE_MIN_VAL;
         end
         `OFS_CORE_MAX: begin
            b = `CORE_MAX_VAL;
         end
         `OFS_PROG_MIN: begin
            b = `PROG_MIN_VAL;
         end
         `OFS_PROG_MAX: begin
            b = `PROG_MAX_VAL;
         end
         `OFS_WORD_TYP: begin
            b = `WORD_TYP_VAL;
         end
         `OFS_BUF_TYP: begin
            b = LARGE_DENSITY ? `BUF_TYP_LARGE : `BUF_TYP_SMALL;
         end
         `OFS_ERASE_TYP: begin
            b = `ERASE_TYP_VAL;
         end
         `OFS_CHIP_TYP, `OFS_CHIP_MAX: begin
            b = `ZERO_BYTE;
         end
         `OFS_WORD_MAX, `OFS_ERASE_MAX: begin
            b = `MAX_FACTOR_VAL;
         end
         `OFS_BUF_MAX: begin
            b = LARGE_DENSITY ? `BUF_MAX_LARGE : `MAX_FACTOR_VAL;
         end
         default: begin
            // Reserved maker area and anything past the table read zero
            b = `ZERO_BYTE;
         end
      endcase
      return b;
   endfunction

   // ----------------------------------------
   // Write cycle detection
   // ----------------------------------------
   logic          write_active;
   logic          write_active_reg;
   logic          write_end;
   logic [15:0]   write_data_reg;
   logic          read_latch;

   // Starts at the later falling edge, ends at the earlier rising edge
   assign write_active = !bus.chip_select_n && !bus.write_strobe_n;
   // Either strobe rising ends the cycle the same way
   assign write_end    = write_active_reg && !write_active;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_active_reg <= 1'b0;
      end else begin
         write_active_reg <= write_active;
      end
   end

   // Data is caught while the cycle is active; the last value before
   // the rising edge is the one that counts.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_data_reg <= 16'h0000;
      end else if (write_active) begin
         write_data_reg <= bus.dq;
      end
   end

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   read_mode_type mode_reg;
   read_mode_type mode_next;
   logic          status_sel_reg;

   // Suspended erase changes nothing in how a write is taken
   always_comb begin
      mode_next = mode_reg;
      if (write_end) begin
         case (write_data_reg[7:0])
            `CMD_QUERY: begin
               mode_next = MODE_QUERY;
            end
            `CMD_READ_ARRAY, `CMD_READ_STATUS, `CMD_READ_ID: begin
               mode_next = MODE_ARRAY;
            end
            default: begin
               mode_next = mode_reg;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= MODE_ARRAY;
      end else begin
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_sel_reg <= 1'b0;
      end else if (write_end) begin
         status_sel_reg <= (write_data_reg[7:0] == `CMD_READ_STATUS);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         command_valid <= 1'b0;
         command_code  <= 8'h00;
      end else begin
         command_valid <= write_end;
         if (write_end) begin
            command_code <= write_data_reg[7:0];
         end
      end
   end

   assign query_mode = (mode_reg == MODE_QUERY);

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [8:0]    addr_reg;
   logic [15:0]   read_word;
   logic [15:0]   dq_out_reg;

   // A low address strobe with select low and no write in progress latches a read
   // address; this also covers the strobe staying low after a write.
   assign read_latch = !bus.address_valid_strobe_low && !bus.chip_select_n
                       && !write_active;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg <= 9'h000;
      end else if (read_latch) begin
         addr_reg <= bus.addr;
      end
   end

   always_comb begin
      if (query_mode) begin
         read_word = {8'h00, table_byte(addr_reg)};
      end else if (status_sel_reg) begin
         read_word = erase_suspended ? (`STATUS_READY | 16'h0040) : `STATUS_READY;
      end else begin
         // No array behind this block: an erased word is returned
         read_word = `ERASED_WORD;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_out_reg <= 16'h0000;
      end else begin
         dq_out_reg <= read_word;
      end
   end

   assign bus.dq_dev_out = dq_out_reg;
   // Never drive while the host may be driving write data
   assign bus.dq_dev_oe  = !bus.chip_select_n && !bus.output_enable_n
                           && bus.write_strobe_n;

endmodule // flash_query_table

/* File: hdl/flash_query_host.sv */
`timescale 1ns/1ps
`include "flash_query_map.svh"
module flash_query_host
   import flash_query_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Flash bus
   flash_bus_if.host        bus
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [3:0]     ctrl_reg;
   logic [8:0]     addr_reg;
   logic [15:0]    wdata_reg;
   logic [15:0]    rdata_reg;
   logic           done_reg;
   host_state_type state_reg;
   host_state_type state_next;
   logic [1:0]     count_reg;
   logic           apb_wr;
   logic           mapped;
   logic           busy;
   logic           start;
   logic           finish;

   assign busy   = (state_reg != ST_IDLE);
   assign apb_wr = psel && penable && pwrite;
   assign mapped = (paddr == `APB_CTRL) || (paddr == `APB_ADDR) || (paddr == `APB_WDATA)
                   || (paddr == `APB_RDATA) || (paddr == `APB_STATUS);
   assign start  = apb_wr && (paddr == `APB_CTRL) && pwdata[`CTRL_START] && !busy;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Protect level is frozen while an operation runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (apb_wr && (paddr == `APB_CTRL) && !busy) begin
         ctrl_reg <= {pwdata[3:1], 1'b0};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg  <= 9'h000;
         wdata_reg <= 16'h0000;
      end else if (apb_wr && !busy) begin
         if (paddr == `APB_ADDR) begin
            addr_reg <= pwdata[8:0];
         end
         if (paddr == `APB_WDATA) begin
            wdata_reg <= pwdata[15:0];
         end
      end
   end

   // Completion wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
      end else if (finish) begin
         done_reg <= 1'b1;
      end else if (apb_wr && (paddr == `APB_STATUS) && pwdata[`STAT_DONE]) begin
         done_reg <= 1'b0;
      end
   end

   always_comb begin
      case (paddr)
         `APB_CTRL:   prdata = {28'h0000000, ctrl_reg};
         `APB_ADDR:   prdata = {23'h000000, addr_reg};
         `APB_WDATA:  prdata = {16'h0000, wdata_reg};
         `APB_RDATA:  prdata = {16'h0000, rdata_reg};
         `APB_STATUS: prdata = {30'h00000000, done_reg, busy};
         default:     prdata = 32'h00000000;
      endcase
   end

   // ----------------------------------------
   // Bus sequencer
   // ----------------------------------------
   assign finish = ((state_reg == ST_WR_END) && (count_reg == 2'd0))
                   || ((state_reg == ST_RD_WAIT) && (count_reg == 2'd0));

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start) begin
               state_next = pwdata[`CTRL_WRITE] ? ST_WR_SETUP : ST_RD_LATCH;
            end
         end
         ST_WR_SETUP: begin
            state_next = ST_WR_PULSE;
         end
         ST_WR_PULSE: begin
            if (count_reg == 2'd0) begin
               state_next = ST_WR_END;
            end
         end
         ST_WR_END: begin
            if (count_reg == 2'd0) begin
               state_next = ST_IDLE;
            end
         end
         ST_RD_LATCH: begin
            state_next = ST_RD_WAIT;
         end
         ST_RD_WAIT: begin
            if (count_reg == 2'd0) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 2'd0;
      end else if (state_next != state_reg) begin
         case (state_next)
            ST_WR_PULSE: count_reg <= 2'(`WRITE_LOW_CYC - 1);
            ST_WR_END:   count_reg <= 2'(`WRITE_HIGH_CYC);
            ST_RD_WAIT:  count_reg <= 2'(`READ_ACCESS_CYC);
            default:     count_reg <= 2'd0;
         endcase
      end else if (count_reg != 2'd0) begin
         count_reg <= count_reg - 2'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 16'h0000;
      end else if ((state_reg == ST_RD_WAIT) && (count_reg == 2'd0)) begin
         rdata_reg <= bus.dq;
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   logic in_write;

   assign in_write        = (state_reg == ST_WR_SETUP) || (state_reg == ST_WR_PULSE);
   // Strobe and select rise together, so either pin ends the write and a
   // following burst read sees a select toggle; end_by_ce is only stored.
   assign bus.write_strobe_n  = !(state_reg == ST_WR_PULSE);
   assign bus.chip_select_n   = !(in_write || (state_reg == ST_RD_LATCH)
                                  || (state_reg == ST_RD_WAIT));
   assign bus.output_enable_n = !(state_reg == ST_RD_WAIT);
   assign bus.address_valid_strobe_low = !(in_write || (state_reg == ST_RD_LATCH));
   assign bus.write_protect_n = ctrl_reg[`CTRL_WP_LEVEL];
   assign bus.addr            = addr_reg;
   assign bus.dq_host_out     = wdata_reg;
   assign bus.dq_host_oe      = in_write;

endmodule // flash_query_host

/* File: verification/flash_query_props.sv */
`timescale 1ns/1ps
module flash_query_props (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Flash bus
   input wire logic        chip_select_n,
   input wire logic        write_strobe_n,
   input wire logic        output_enable_n,
   input wire logic        address_valid_strobe_low,
   input wire logic        write_protect_n,
   input wire logic [8:0]  addr,
   input wire logic [15:0] dq_host_out,
   input wire logic        dq_host_oe,
   input wire logic [15:0] dq_dev_out,
   input wire logic        dq_dev_oe,
   input wire logic [15:0] dq,
   // Table state
   input wire logic        query_mode
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ----------------------------------------
   // Write cycle
   // ----------------------------------------
   a_strobe_in_select: assert property (!write_strobe_n |-> !chip_select_n)
      else $error("write strobe low outside chip select");
   a_setup_before_pulse: assert property ($fell(write_strobe_n) |->
      $past(chip_select_n) == 1'b0 && $past(address_valid_strobe_low) == 1'b0)
      else $error("write pulse without setup cycle");
   a_pulse_ends_both: assert property ($fell(write_strobe_n) |->
      ##1 (write_strobe_n && chip_select_n))
      else $error("write pulse not ended by both strobes");
   a_write_data_held: assert property ($fell(write_strobe_n) |->
      dq_host_oe && $stable(dq_host_out) && $stable(addr))
      else $error("write data or address moved");
   a_protect_held: assert property (!write_strobe_n |-> $stable(write_protect_n))
      else $error("write protect moved in write");
   a_device_quiet: assert property (!write_strobe_n |-> !dq_dev_oe)
      else $error("device drives during write");
   a_no_contention: assert property (!(dq_dev_oe && dq_host_oe))
      else $error("both ends drive data");

   // ----------------------------------------
   // Read cycle
   // ----------------------------------------
   a_read_window: assert property ($fell(output_enable_n) |->
      ($past(address_valid_strobe_low) == 1'b0) ##0 !output_enable_n [*3] ##1 output_enable_n)
      else $error("read window wrong");
   a_dq_from_device: assert property (dq_dev_oe |-> dq == dq_dev_out)
      else $error("data bus not showing device word");
   a_upper_lanes_zero: assert property (query_mode && dq_dev_oe |-> dq[15:8] == 8'h00)
      else $error("upper lanes not zero in query");
   a_signature_byte: assert property (query_mode && !output_enable_n &&
      $past(!output_enable_n) && addr == 9'h010 |-> dq == 16'h0051)
      else $error("signature byte wrong");

   c_write: cover property ($rose(write_strobe_n));
   c_query_read: cover property (query_mode && dq_dev_oe);
   c_signature: cover property (query_mode && !output_enable_n && addr == 9'h010);
endmodule // flash_query_props

/* File: verification/flash_query_table_tb.sv */
`timescale 1ns/1ps
`include "flash_query_map.svh"
module flash_query_table_tb;
   import flash_query_pkg::*;
   // Arbitrary value, only has to match between model and design
   localparam logic [15:0] CMDSET = 16'h6B2D;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        erase_suspended, query_mode, command_valid;
   logic [7:0]  command_code;
   logic [7:0]  leave [3] = '{8'hFF, 8'h70, 8'h90};
   logic [31:0] exp_q [$];
   int          num_errors, checked, seed, mode, pulses, cmds, i;

   flash_bus_if bus_if ();
   flash_query_host i_flash_query_host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(bus_if.host));
   flash_query_table #(.CMDSET_CODE(CMDSET), .LARGE_DENSITY(1'b0)) i_flash_query_table (
      .pclk(pclk), .presetn(presetn), .bus(bus_if.device), .erase_suspended(erase_suspended),
      .query_mode(query_mode), .command_valid(command_valid), .command_code(command_code));
   flash_query_props i_flash_query_props (.pclk(pclk), .presetn(presetn),
      .chip_select_n(bus_if.chip_select_n), .write_strobe_n(bus_if.write_strobe_n),
      .output_enable_n(bus_if.output_enable_n), .write_protect_n(bus_if.write_protect_n),
      .address_valid_strobe_low(bus_if.address_valid_strobe_low), .addr(bus_if.addr),
      .dq_host_out(bus_if.dq_host_out), .dq_host_oe(bus_if.dq_host_oe),
      .dq_dev_out(bus_if.dq_dev_out), .dq_dev_oe(bus_if.dq_dev_oe),
      .dq(bus_if.dq), .query_mode(query_mode));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk) if (command_valid === 1'b1) pulses++;

   // ----------------------------------------
   // Reference model
   // ----------------------------------------
   function automatic logic [31:0] model(input int a);
      if (mode == 0) return 32'hFFFF;
      if (mode == 2) return erase_suspended ? 32'h00C0 : 32'h0080;
      case (a)
         'h10: return 32'h51;
         'h11: return 32'h52;
         'h12: return 32'h59;
         'h13: return {24'h0, CMDSET[7:0]};
         'h14: return {24'h0, CMDSET[15:8]};
         'h15: return 32'h0A;
         'h16: return 32'h01;
         'h1B: return 32'h17;
         'h1C: return 32'h20;
         'h1D: return 32'h85;
         'h1E: return 32'h95;
         'h1F: return 32'h06;
         'h20, 'h21: return 32'h0A;
         'h23, 'h24, 'h25: return 32'h02;
         default: return 32'h0;
      endcase
   endfunction

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) check(32'h0, 32'h1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Write protect stays released in every command, so it never moves in mid-write
   task automatic flash_op(input logic w, input int a, input logic [15:0] d);
      logic [31:0] s;
      logic        e;
      int          n;
      apb(1'b1, `APB_ADDR, a, s, e);
      apb(1'b1, `APB_WDATA, {16'h0, d}, s, e);
      apb(1'b1, `APB_CTRL, {28'h0, 1'b1, 1'b0, w, 1'b1}, s, e);
      n = 0;
      s = 32'h0;
      while (s[1] !== 1'b1 && n < 50) begin
         apb(1'b0, `APB_STATUS, 32'h0, s, e);
         n++;
      end
      check(s[1], 32'h1);
      apb(1'b1, `APB_STATUS, 32'h2, s, e);
      apb(1'b0, `APB_RDATA, 32'h0, r, e);
   endtask

   task automatic cmd(input logic [7:0] c);
      flash_op(1'b1, 0, {8'h00, c});
      cmds++;
      mode = (c == 8'h98) ? 1 : (c == 8'h70) ? 2 : 0;
      check(command_code, c);
      check(query_mode, mode == 1);
      check(pulses, cmds);
   endtask

   task automatic rd(input int a);
      flash_op(1'b0, a, 16'h0);
      exp_q.push_back(model(a));
      check(r, exp_q.pop_front());
   endtask

   task automatic report_and_stop;
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      #3000000;
      num_errors++;
      report_and_stop;
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      logic e;
      seed = 78724;
      {psel, penable, pwrite, erase_suspended} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({bus_if.chip_select_n, bus_if.write_strobe_n, bus_if.output_enable_n,
             bus_if.write_protect_n}, 32'hE);
      apb(1'b0, `APB_CTRL, 32'h0, r, e);
      check(r, 32'h0);
      apb(1'b0, 12'h020, 32'h0, r, e);
      check({e, r[30:0]}, 32'h80000000);
      rd('h10);
      cmd(8'h98);
      for (i = 0; i <= 'h1A; i++) rd(i);
      for (i = 'h1B; i <= 'h26; i++) rd(i);
      for (i = 0; i < 8; i++) rd({$random(seed)} % 'h27);
      for (i = 0; i < 3; i++) begin
         cmd(leave[i]);
         rd('h1F);
         cmd(8'h98);
      end
      erase_suspended <= 1'b1;
      cmd(8'h70);
      rd('h10);
      cmd(8'h98);
      rd('h11);
      cmd(8'hFF);
      rd('h12);
      report_and_stop;
   end
endmodule // flash_query_table_tb
